// ### bench/fesp_dev_model.sv
// Behavioural flash emulator on the far side of the host's pins.
// Assumes the host clocks the serial bus and sends unlock bytes at 9600 baud.
module fesp_dev_model #(
	parameter logic [15:0] DEV_ID   = 16'hA5C3,
	parameter logic [31:0] LOCK_KEY = 32'hC0DE0042,
	parameter int          BUSY_NS  = 20000
) (
	input  wire logic i_chip_reset_n,
	input  wire logic i_program_entry_n,
	input  wire logic i_select_n,
	input  wire logic i_sck,
	input  wire logic i_mosi,
	input  wire logic i_rx,
	output logic      o_miso
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam real BIT_NS = 1.0e9 / 9600;
	logic [7:0]  mem [int];
	logic [7:0]  cmd, osr, rxb;
	logic [23:0] adr;
	int          nbit, k;
	bit          locked = 1, halted = 0;
	time         busy_end = 0;
	initial o_miso = 1'b0;
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	always @(negedge i_chip_reset_n) begin
		locked = 1;
		halted = 0;
	end
	always @(negedge i_select_n) nbit = 0;
	// A released line must not keep showing the last bit.
	always @(posedge i_select_n) o_miso = ~o_miso;
	always @(posedge i_sck) if (!i_select_n && !i_program_entry_n && !locked) begin
		rxb = {rxb[6:0], i_mosi};
		nbit++;
		if (nbit % 8 == 0) begin
			k = nbit / 8 - 1;
			if (k == 0) cmd = rxb;
			else if (k < 4) adr = {adr[15:0], rxb};
			if (k == 3 && cmd == 8'h50) begin
				for (int i = 0; i < 2048; i++) mem.delete(int'(adr & 24'h7FF800) + i);
				busy_end = $time + BUSY_NS;
			end
			if (k == 3 && cmd == 8'hC7 && adr == 24'h94809A) begin
				mem.delete();
				busy_end = $time + BUSY_NS;
			end
			if (k >= 4 && cmd == 8'h44) begin
				mem[adr + k - 4] = rxb;
				busy_end = $time + BUSY_NS;
			end
		end
	end
	always @(negedge i_sck) if (!i_select_n && !i_program_entry_n && !locked) begin
		if (nbit % 8 == 0) begin
			k = nbit / 8;
			case (cmd)
				8'h9F: osr = (k == 1) ? DEV_ID[15:8] : DEV_ID[7:0];
				8'hD7: osr = {$time >= busy_end, 5'b00111, 2'b01};
				8'h03: osr = rd(adr + k - 4);
				default: osr = 8'h00;
			endcase
		end
		o_miso = osr[7 - nbit % 8];
	end
	// Only one line is wired here, so it is always the one that spoke first.
	initial begin : unlock_rx
		logic [63:0] msg;
		forever begin
			for (int b = 0; b < 8; b++) begin
				@(negedge i_rx);
				#(BIT_NS / 2);
				for (int i = 0; i < 8; i++) begin
					#(BIT_NS);
					msg = {i_rx, msg[63:1]};
				end
				#(BIT_NS);
			end
			if (locked && !halted && msg == {LOCK_KEY, 32'h56874312}) locked = 0;
			else begin
				locked = 1;
				halted = 1;
			end
		end
	end
endmodule // fesp_dev_model

// ### bench/fesp_host_sva.sv
// Checker on the programming host's ports: pin timing, refusals, streams.
// Assumes the one clock i_clk with synchronous active-high i_rst.
`include "fesp_map.vh"
module fesp_host_sva #(
	parameter ENTRY_CYC = 20
) (
	input logic        i_clk,
	input logic        i_rst,
	input logic        i_cmd_valid,
	input logic        o_cmd_ready,
	input logic [7:0]  i_cmd_op,
	input logic [23:0] i_cmd_addr,
	input logic        i_enter,
	input logic        i_unlock,
	input logic [7:0]  o_rd_data,
	input logic        o_rd_valid,
	input logic        i_rd_ready,
	input logic        o_busy,
	input logic        o_bad_cmd,
	input logic        o_chip_reset_n,
	input logic        o_program_entry_n,
	input logic        o_prog_select_n,
	input logic        o_prog_serial_clock,
	input logic        o_prog_data_in,
	input logic        o_unlock_tx
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	localparam int BIT = `FESP_BIT_CYC;
	wire take = i_cmd_valid && o_cmd_ready && !i_enter && !i_unlock;
	logic [31:0] low_cnt;
	logic [15:0] run;
	// Counts how long the chip reset has been low and the unlock line has held its level.
	always_ff @(posedge i_clk) begin
		low_cnt <= (i_rst || o_chip_reset_n) ? 32'd0 : low_cnt + 32'd1;
		run <= (i_rst || $changed(o_unlock_tx)) ? 16'd1 : run + 16'd1;
	end
	sequence sck_high_phase;
		o_prog_serial_clock [*3] ##1 !o_prog_serial_clock;
	endsequence
	entry_wait_a: assert property ($rose(o_chip_reset_n) |->
		low_cnt >= ENTRY_CYC && !o_program_entry_n) else $error("entry hold too short");
	sck_rate_a: assert property ($rose(o_prog_serial_clock) |=>
		sck_high_phase) else $error("serial clock high phase not four cycles");
	sel_start_a: assert property ($fell(o_prog_select_n) |->
		!o_prog_serial_clock) else $error("select fell with clock high");
	id_start_a: assert property (take && i_cmd_op == 8'h9F |=>
		o_busy && !o_prog_select_n) else $error("command did not start");
	mosi_hold_a: assert property (o_prog_serial_clock |->
		$stable(o_prog_data_in)) else $error("data moved while clock high");
	bad_op_a: assert property (take && !(i_cmd_op inside {8'h9F, 8'hD7, 8'h03,
		8'h50, 8'hC7, 8'h44}) |=> o_bad_cmd) else $error("unknown opcode accepted");
	bad_addr_a: assert property (take && i_cmd_op == 8'h03 &&
		i_cmd_addr > 24'h07FFFF |=> o_bad_cmd) else $error("read past end accepted");
	rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=>
		o_rd_valid && $stable(o_rd_data)) else $error("read byte lost in stall");
	uart_bit_a: assert property ($rose(o_unlock_tx) |->
		run % BIT == 0) else $error("unlock bit time wrong");
	sel_end_a: assert property ($rose(o_prog_select_n) |->
		!o_prog_serial_clock) else $error("select rose with clock high");
endmodule // fesp_host_sva

bind fesp_host fesp_host_sva #(.ENTRY_CYC(ENTRY_CYC)) u_sva (.*);

// ### bench/fesp_host_tb.sv
// Self-checking bench for the programming host against the emulator model.
// Assumes the checker is bound through its own file.
module fesp_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] ID  = 16'hA5C3;
	localparam logic [31:0] KEY = 32'hC0DE0042;
	logic        i_clk = 0, i_rst = 1, i_cmd_valid = 0, i_cmd_wait_rdy = 0;
	logic        i_enter = 0, i_unlock = 0, i_wr_valid = 0, i_rd_ready = 0;
	logic [7:0]  i_cmd_op = 0, i_wr_data = 0;
	logic [23:0] i_cmd_addr = 0;
	logic [15:0] i_cmd_len = 0;
	logic [31:0] i_unlock_key = KEY;
	wire         o_cmd_ready, o_wr_ready, o_rd_valid, o_busy, o_bad_cmd, o_chip_reset_n;
	wire         o_program_entry_n, o_prog_select_n, o_prog_serial_clock, o_prog_data_in;
	wire         i_prog_data_out, o_unlock_tx;
	wire [7:0]   o_rd_data;
	int          errors = 0, checked = 0;
	logic [7:0]  got [$], wq [$];
	always #50 i_clk = ~i_clk;
	fesp_host #(.ENTRY_CYC(20)) uut (.*);
	fesp_dev_model #(.DEV_ID(ID), .LOCK_KEY(KEY)) dev (.i_chip_reset_n(o_chip_reset_n),
		.i_program_entry_n(o_program_entry_n), .i_select_n(o_prog_select_n),
		.i_sck(o_prog_serial_clock), .i_mosi(o_prog_data_in), .i_rx(o_unlock_tx),
		.o_miso(i_prog_data_out));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick;
		@(posedge i_clk);
		#5;
	endtask
	// Runs both streams until idle; the read side stalls half the time.
	task automatic settle(input int lim);
		logic       tv, tw;
		logic [7:0] td;
		for (int n = 0; o_cmd_ready !== 1'b1 || o_busy !== 1'b0 || o_rd_valid === 1'b1; n++) begin
			tv = o_rd_valid & i_rd_ready;
			tw = o_wr_ready & i_wr_valid;
			td = o_rd_data;
			tick();
			if (tv) got.push_back(td);
			if (tw) void'(wq.pop_front());
			i_wr_valid = wq.size() > 0;
			i_wr_data = i_wr_valid ? wq[0] : 8'h00;
			i_rd_ready = n[1];
			if (n > lim) begin
				check(0, 1);
				report_and_stop();
			end
		end
	endtask
	task automatic run(input logic [7:0] op, input logic [23:0] adr, input logic [15:0] len,
		input logic wrdy, input logic bad);
		got = {};
		i_cmd_op = op;
		i_cmd_addr = adr;
		i_cmd_len = len;
		i_cmd_wait_rdy = wrdy;
		i_wr_valid = wq.size() > 0;
		i_wr_data = i_wr_valid ? wq[0] : 8'h00;
		i_cmd_valid = 1'b1;
		tick();
		i_cmd_valid = 1'b0;
		check({o_bad_cmd, o_busy}, {bad, !bad});
		settle(40000);
	endtask
	////////////////////////////////////////
	task automatic t_entry_unlock;
		i_enter = 1'b1;
		tick();
		i_enter = 1'b0;
		tick();
		settle(200);
		check({o_chip_reset_n, o_program_entry_n}, 2'b10);
		i_unlock = 1'b1;
		tick();
		i_unlock = 1'b0;
		tick();
		settle(95000);
	endtask
	task automatic t_status(input logic rdy);
		run(8'hD7, 24'h0, 16'd2, 1'b0, 1'b0);
		check(got.size(), 2);
		foreach (got[i]) check(got[i][7:2], {rdy, 5'b00111});
	endtask
	task automatic t_id;
		run(8'h9F, 24'h0, 16'd2, 1'b0, 1'b0);
		check({got[0], got[1]}, ID);
	endtask
	task automatic t_write_read;
		for (int i = 0; i < 8; i++) wq.push_back(8'h30 + 8'(i));
		run(8'h44, 24'h000100, 16'd8, 1'b1, 1'b0);
		check(wq.size(), 0);
		run(8'h03, 24'h000102, 16'd8, 1'b0, 1'b0);
		check(got.size(), 8);
		for (int i = 0; i < 8; i++) check(got[i], i < 6 ? 8'h32 + 8'(i) : 8'hFF);
	endtask
	task automatic t_erase;
		run(8'h50, 24'h000104, 16'd0, 1'b0, 1'b0);
		t_status(1'b0);
		run(8'hD7, 24'h0, 16'd1, 1'b1, 1'b0);
		run(8'h03, 24'h0000FE, 16'd4, 1'b0, 1'b0);
		check(got.size(), 4);
		foreach (got[i]) check(got[i], 8'hFF);
		for (int i = 0; i < 4; i++) wq.push_back(8'h00);
		run(8'h44, 24'h07F000, 16'd4, 1'b1, 1'b0);
		run(8'h03, 24'h07F000, 16'd4, 1'b0, 1'b0);
		check(got.size(), 4);
		foreach (got[i]) check(got[i], 8'h00);
		run(8'hC7, 24'h0, 16'd0, 1'b1, 1'b0);
		run(8'h03, 24'h07F000, 16'd4, 1'b0, 1'b0);
		check(got.size(), 4);
		foreach (got[i]) check(got[i], 8'hFF);
	endtask
	task automatic t_refuse;
		run(8'h11, 24'h0, 16'd4, 1'b0, 1'b1);
		run(8'h03, 24'h080000, 16'd4, 1'b0, 1'b1);
		run(8'h44, 24'h000100, 16'd6, 1'b0, 1'b1);
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		#5;
		i_rst = 1'b0;
		settle(10);
		t_entry_unlock();
		t_status(1'b1);
		t_id();
		t_write_read();
		t_erase();
		t_refuse();
		report_and_stop();
	end
endmodule // fesp_host_tb

// ### common/fesp_map.vh
// Constants for the flash emulator programming host: opcodes, keys, timing.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef FESP_MAP_VH
`define FESP_MAP_VH
`define FESP_OP_READ_ID      8'h9F
`define FESP_OP_READ_STATUS  8'hD7
`define FESP_OP_READ         8'h03
`define FESP_OP_PAGE_ERASE   8'h50
`define FESP_OP_BULK_ERASE   8'hC7
`define FESP_OP_WRITE_PROG   8'h44
`define FESP_BULK_KEY        24'h94809A
`define FESP_COOKIE          32'h12438756
`define FESP_STATUS_RDY_BIT  7
`define FESP_CLK_HZ          10000000
`define FESP_ENTRY_MS        10
`define FESP_ENTRY_CYC       ((`FESP_CLK_HZ / 1000) * `FESP_ENTRY_MS)
`define FESP_SCK_MAX_KHZ     3330
`define FESP_SCK_HALF_CYC    4
`define FESP_BAUD            9600
`define FESP_BIT_CYC         (`FESP_CLK_HZ / `FESP_BAUD)
`define FESP_ADDR_MAX        24'h07FFFF
`endif

// ### hdl/fesp_buf2.v
// Two-entry valid/ready buffer holding bytes read back from the device.
// Assumes a single clock domain; the drain side may stall at will.
module fesp_buf2 #(
	parameter WIDTH = 8
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_data,
	input  wire             i_valid,
	output wire             o_ready,
	output wire [WIDTH-1:0] o_data,
	output wire             o_valid,
	input  wire             i_ready
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wr_ptr;
	reg             rd_ptr;
	reg [1:0]       count;
	wire            push = i_valid && (count != 2'h2);
	wire            pop  = (count != 2'h0) && i_ready;

	assign o_ready = (count != 2'h2);
	assign o_valid = (count != 2'h0);
	assign o_data  = mem[rd_ptr];

	always @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= i_data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // fesp_buf2

// ### hdl/fesp_host.v
// Programming host that drives the flash emulator over its serial bus,
// its reset and entry pins, and a UART line for the unlock message.
// Assumes i_clk at 10 MHz and synchronous active-high i_rst.
// Functional notes
// RL1: Hold reset and entry low 10 ms first.
// RL2: Serial clock stays below 3.33 MHz.
// RL3: Select falls, then opcode, then operands.
// RL4: Device samples data on rising clock, MSB first.
// RL5: Device shifts on falling edge; host samples rising.
// RL6: Opcodes 9F id, D7 status, 03 read.
// RL7: Opcodes 50, C7, 44; send no others.
// RL8: Identifier read returns two bytes.
// RL9: Status byte repeats while clocks continue.
// RL10: Status bit 7 high means ready.
// RL11: Read takes three address bytes, MSB first.
// RL12: Read addresses stay within 0 to 7FFFF.
// RL13: Read data advances one byte per byte.
// RL14: Page erase clears addressed 2048-byte page.
// RL15: After page erase poll ready or wait.
// RL16: Bulk erase needs key 94809A after opcode.
// RL17: After bulk erase poll ready or wait.
// RL18: Write words aligned, at most 16 KB.
// RL19: After write poll ready or wait.
// RL20: Unlock UART 9600 baud, 8N1, no flow.
// RL21: Unlock message is cookie then key LSB first.
// RL22: Only one unlock attempt; mismatch halts device.
// RL23: Device keeps using first UART that spoke.
// RL24: Raised select ends the current command.
`include "fesp_map.vh"
module fesp_host #(
	parameter ENTRY_CYC = `FESP_ENTRY_CYC,
	parameter MAX_WORDS = 4096
) (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_cmd_valid,
	output reg         o_cmd_ready,
	input  wire [7:0]  i_cmd_op,
	input  wire [23:0] i_cmd_addr,
	input  wire [15:0] i_cmd_len,
	input  wire        i_cmd_wait_rdy,
	input  wire        i_enter,
	input  wire        i_unlock,
	input  wire [31:0] i_unlock_key,
	input  wire [7:0]  i_wr_data,
	input  wire        i_wr_valid,
	output reg         o_wr_ready,
	output reg  [7:0]  o_rd_data,
	output reg         o_rd_valid,
	input  wire        i_rd_ready,
	output reg         o_busy,
	output reg         o_bad_cmd,
	output reg         o_chip_reset_n,
	output reg         o_program_entry_n,
	output reg         o_prog_select_n,
	output reg         o_prog_serial_clock,
	output reg         o_prog_data_in,
	input  wire        i_prog_data_out,
	output reg         o_unlock_tx
);
	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_ENTRY = 7'h02;
	localparam [6:0] S_SHIFT = 7'h04;
	localparam [6:0] S_NEXT  = 7'h08;
	localparam [6:0] S_GAP   = 7'h10;
	localparam [6:0] S_UART  = 7'h20;
	localparam [6:0] S_POLL  = 7'h40;
	localparam integer BIT_CYC = `FESP_BIT_CYC;
	localparam [23:0] ENTRY_W = ENTRY_CYC[23:0];
	localparam [11:0] BIT_W   = BIT_CYC[11:0];

	////////////////////////////////////////////////////////////////////////
	reg [2:0]  miso_sync;
	reg [6:0]  state;
	reg [23:0] timer;
	reg [7:0]  op;
	reg [23:0] addr;
	reg [15:0] remain;
	reg [2:0]  hdr_left;
	reg        wait_rdy;
	reg [7:0]  tx_byte;
	reg [7:0]  rx_byte;
	reg [2:0]  bit_idx;
	reg [1:0]  phase;
	reg        data_phase;
	reg [63:0] umsg;
	reg [3:0]  ubit;
	reg [3:0]  ubyte;
	reg [7:0]  buf_in;
	reg        buf_in_valid;
	wire       buf_ready;
	wire [7:0] buf_data;
	wire       buf_valid;
	wire       out_load = !o_rd_valid || i_rd_ready;
	reg        miso_hold;
	wire       miso_bit = (miso_sync[2] == miso_sync[1]) ? miso_sync[2] : miso_hold;
	wire       is_read = (op == `FESP_OP_READ) || (op == `FESP_OP_READ_ID) ||
	                     (op == `FESP_OP_READ_STATUS);
	wire       op_ok = (i_cmd_op == `FESP_OP_READ_ID) ||
	                   (i_cmd_op == `FESP_OP_READ_STATUS) ||
	                   (i_cmd_op == `FESP_OP_READ) ||
	                   (i_cmd_op == `FESP_OP_PAGE_ERASE) ||
	                   (i_cmd_op == `FESP_OP_BULK_ERASE) ||
	                   (i_cmd_op == `FESP_OP_WRITE_PROG);
	// Out-of-range reads and unaligned or oversized writes are refused here.
	wire       args_ok = (i_cmd_op == `FESP_OP_READ) ?
	                     ({1'b0, i_cmd_addr} + {9'h000, i_cmd_len} <=
	                      {1'b0, `FESP_ADDR_MAX} + 25'h0000001) : // [RL12]
	                     (i_cmd_op == `FESP_OP_WRITE_PROG) ?
	                     (i_cmd_addr[1:0] == 2'h0 && i_cmd_len[1:0] == 2'h0 &&
	                      i_cmd_len <= MAX_WORDS * 4 && i_cmd_len != 16'h0000) : 1'b1; // [RL18]

	fesp_buf2 #(.WIDTH(8)) u_buf (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_data  (buf_in),
		.i_valid (buf_in_valid),
		.o_ready (buf_ready),
		.o_data  (buf_data),
		.o_valid (buf_valid),
		.i_ready (out_load)
	);

	// The output stage reloads only when empty or being taken, so the buffer
	// pops exactly when a byte moves forward and a stalled reader loses none.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
		end else if (out_load) begin
			o_rd_data  <= buf_data;
			o_rd_valid <= buf_valid;
		end
	end

	// The data-out pin is asynchronous to us; the last two stages must agree.
	always @(posedge i_clk) begin
		if (i_rst) begin
			miso_sync <= 3'h0;
			miso_hold <= 1'b0;
		end else begin
			miso_sync <= {miso_sync[1:0], i_prog_data_out};
			if (miso_sync[2] == miso_sync[1])
				miso_hold <= miso_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge i_clk) begin
		if (i_rst) begin
			state <= S_IDLE;
			timer <= 24'h000000;
			op <= 8'h00;
			addr <= 24'h000000;
			remain <= 16'h0000;
			hdr_left <= 3'h0;
			wait_rdy <= 1'b0;
			tx_byte <= 8'h00;
			rx_byte <= 8'h00;
			bit_idx <= 3'h0;
			phase <= 2'h0;
			data_phase <= 1'b0;
			umsg <= 64'h0;
			ubit <= 4'h0;
			ubyte <= 4'h0;
			buf_in <= 8'h00;
			buf_in_valid <= 1'b0;
			o_cmd_ready <= 1'b0;
			o_wr_ready <= 1'b0;
			o_busy <= 1'b0;
			o_bad_cmd <= 1'b0;
			o_chip_reset_n <= 1'b1;
			o_program_entry_n <= 1'b1;
			o_prog_select_n <= 1'b1;
			o_prog_serial_clock <= 1'b0;
			o_prog_data_in <= 1'b0;
			o_unlock_tx <= 1'b1;
		end else begin
			buf_in_valid <= 1'b0;
			o_wr_ready <= 1'b0;
			o_bad_cmd <= 1'b0;
			case (state)
			S_IDLE: begin
				o_cmd_ready <= 1'b1;
				o_busy <= 1'b0;
				if (i_enter) begin
					o_cmd_ready <= 1'b0;
					o_busy <= 1'b1;
					o_chip_reset_n <= 1'b0;
					o_program_entry_n <= 1'b0;
					timer <= ENTRY_W;
					state <= S_ENTRY;
				end else if (i_unlock) begin
					o_cmd_ready <= 1'b0;
					o_busy <= 1'b1;
					umsg <= {`FESP_COOKIE, i_unlock_key[7:0], i_unlock_key[15:8],
					         i_unlock_key[23:16], i_unlock_key[31:24]}; // [RL21]
					ubyte <= 4'h0;
					ubit <= 4'h0;
					timer <= {12'h000, BIT_W};
					o_unlock_tx <= 1'b0;
					state <= S_UART;
				end else if (i_cmd_valid && o_cmd_ready) begin
					o_cmd_ready <= 1'b0;
					if (!op_ok || !args_ok) begin
						o_bad_cmd <= 1'b1; // [RL7]
					end else begin
						o_busy <= 1'b1;
						op <= i_cmd_op;
						addr <= (i_cmd_op == `FESP_OP_BULK_ERASE) ? `FESP_BULK_KEY :
						        i_cmd_addr; // [RL16]
						hdr_left <= (i_cmd_op == `FESP_OP_READ_ID ||
						             i_cmd_op == `FESP_OP_READ_STATUS) ? 3'h1 : 3'h4; // [RL11]
						remain <= (i_cmd_op == `FESP_OP_READ_ID) ? 16'h0002 :
						          (i_cmd_op == `FESP_OP_READ_STATUS) ?
						          ((i_cmd_len != 16'h0000) ? i_cmd_len : 16'h0001) :
						          (i_cmd_op == `FESP_OP_READ ||
						           i_cmd_op == `FESP_OP_WRITE_PROG) ? i_cmd_len : 16'h0000; // [RL8]
						wait_rdy <= i_cmd_wait_rdy;
						tx_byte <= i_cmd_op;
						bit_idx <= 3'h7;
						phase <= 2'h0;
						data_phase <= 1'b0;
						o_prog_select_n <= 1'b0; // [RL3]
						o_prog_data_in <= i_cmd_op[7]; // [RL4]
						timer <= 24'h000000;
						state <= S_SHIFT;
					end
				end
			end
			S_ENTRY: begin
				// Keep chip reset low the whole entry wait, then release it.
				if (timer != 24'h000000)
					timer <= timer - 24'h000001; // [RL1]
				else begin
					o_chip_reset_n <= 1'b1;
					state <= S_IDLE;
				end
			end
			S_SHIFT: begin
				// Each high half, and each low half within a byte, lasts four system cycles: 1.25 MHz. [RL2]
				// The slower rate gives returned data time to pass the synchroniser.
				if (timer[1:0] != `FESP_SCK_HALF_CYC - 1)
					timer <= timer + 24'h000001;
				else begin
					timer <= 24'h000000;
					if (!o_prog_serial_clock) begin
						o_prog_serial_clock <= 1'b1;
						rx_byte <= {rx_byte[6:0], miso_bit}; // [RL5]
					end else begin
						o_prog_serial_clock <= 1'b0;
						if (bit_idx != 3'h0) begin
							bit_idx <= bit_idx - 3'h1;
							o_prog_data_in <= tx_byte[bit_idx - 3'h1]; // [RL4]
						end else
							state <= S_NEXT;
					end
				end
			end
			S_NEXT: begin
				// Byte done: push read data, then pick the next byte to send.
				if (data_phase && is_read && !buf_ready) begin
					state <= S_NEXT;
				end else if (hdr_left <= 3'h1 && remain != 16'h0000 &&
				             op == `FESP_OP_WRITE_PROG && !i_wr_valid) begin
					state <= S_NEXT;
				end else begin
					if (data_phase && is_read) begin
						buf_in <= rx_byte;
						buf_in_valid <= 1'b1; // [RL13]
					end
					if (hdr_left > 3'h1) begin
						hdr_left <= hdr_left - 3'h1;
						tx_byte <= addr[23:16]; // [RL11]
						o_prog_data_in <= addr[23];
						addr <= {addr[15:0], 8'h00};
						bit_idx <= 3'h7;
						state <= S_SHIFT;
					end else if (remain != 16'h0000 && op == `FESP_OP_WRITE_PROG &&
					             i_wr_valid) begin
						hdr_left <= 3'h0;
						data_phase <= 1'b1;
						remain <= remain - 16'h0001;
						tx_byte <= i_wr_data;
						o_prog_data_in <= i_wr_data[7];
						o_wr_ready <= 1'b1;
						bit_idx <= 3'h7;
						state <= S_SHIFT;
					end else if (remain != 16'h0000 && is_read) begin
						hdr_left <= 3'h0;
						data_phase <= 1'b1;
						remain <= remain - 16'h0001;
						tx_byte <= 8'h00;
						o_prog_data_in <= 1'b0;
						bit_idx <= 3'h7;
						state <= S_SHIFT;
					end else begin
						o_prog_select_n <= 1'b1; // [RL24]
						timer <= 24'h000000;
						state <= S_GAP;
					end
				end
			end
			S_GAP: begin
				// Select stays high a few cycles so the device sees a clean edge.
				if (timer[1:0] != 2'h3)
					timer <= timer + 24'h000001;
				else if (op == `FESP_OP_READ_STATUS && wait_rdy &&
				         data_phase && !rx_byte[`FESP_STATUS_RDY_BIT]) begin
					state <= S_POLL; // [RL10]
				end else if (wait_rdy && (op == `FESP_OP_PAGE_ERASE ||
				            op == `FESP_OP_BULK_ERASE || op == `FESP_OP_WRITE_PROG)) begin
					state <= S_POLL; // [RL15] [RL17] [RL19]
				end else
					state <= S_IDLE;
			end
			S_POLL: begin
				// Poll with a fresh single status read until the ready bit is set.
				op <= `FESP_OP_READ_STATUS;
				tx_byte <= `FESP_OP_READ_STATUS; // [RL9]
				hdr_left <= 3'h1;
				remain <= 16'h0001;
				wait_rdy <= 1'b1;
				data_phase <= 1'b0;
				bit_idx <= 3'h7;
				timer <= 24'h000000;
				o_prog_select_n <= 1'b0; // [RL3]
				o_prog_data_in <= 1'b1;
				state <= S_SHIFT;
			end
			S_UART: begin
				// 8N1 frames, LSB first within each byte, no flow control. [RL20]
				if (timer != 24'h000001)
					timer <= timer - 24'h000001;
				else begin
					timer <= {12'h000, BIT_W};
					ubit <= ubit + 4'h1;
					if (ubit < 4'h8)
						o_unlock_tx <= umsg[56 + ubit[2:0]];
					else if (ubit == 4'h8)
						o_unlock_tx <= 1'b1;
					else if (ubyte == 4'h7) begin
						state <= S_IDLE; // [RL22]
					end else begin
						ubit <= 4'h0;
						ubyte <= ubyte + 4'h1;
						umsg <= {umsg[55:0], 8'h00};
						o_unlock_tx <= 1'b0;
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // fesp_host
